/* File: verilog/compat_control_addressing.sv */
// compatibility control register, host decode and address remapping
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "compat_control_defines.svh"

module compat_control_addressing #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_enable_pin,
  input wire logic [16:0] cpu_addr,
  input wire logic [15:0] crt_mem_counter,
  input wire logic [15:0] crt_std_addr,
  input wire logic [7:0] font_data,
  input wire logic [7:0] plane3_ext_attr,
  input wire logic underline_line,
  output logic host_io_en,
  output logic host_mem_en,
  output logic port_3c3_decode,
  output logic [15:0] cpu_linear_addr,
  output logic [15:0] crt_linear_addr,
  output logic [2:0] de_skew,
  output logic refresh_skewed,
  output logic [7:0] font_out
);

  compat_control_pkg::state_t st;
  compat_control_pkg::state_t next_st;

  // ****************************************************************
  // address remapping
  // ****************************************************************
  function automatic logic [15:0] remap_cpu(
    input logic [16:0] a,
    input logic [7:0] cc,
    input logic [4:0] mc,
    input logic [1:0] pg
  );
    logic [15:0] la;
    la = a[15:0];
    if (mc[`BIT_CHAIN4]) begin
      if (cc[`BIT_EXT256_EN]) begin
        la = {a[15:2], pg[`BIT_PAGE_SEL], 1'b0};
        if (cc[`BIT_EXT256_MODE]) begin
          la[0] = a[16];
        end else begin
          la[0] = pg[`BIT_EXT_PAGE_SEL];
        end
      end else if (cc[`BIT_SEQ_CHAIN4]) begin
        la = {a[1:0], a[15:2]};
      end else begin
        la = {a[15:2], a[1:0]};
      end
    end else if (mc[`BIT_CHAIN] && cc[`BIT_SEQ_CHAIN]) begin
      la = {a[0], a[15:1]};
    end
    return la;
  endfunction : remap_cpu

  // ****************************************************************
  // register access helpers
  // ****************************************************************
  function automatic logic [7:0] merge_byte(
    input logic [7:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    return strb[0] ? wd[7:0] : old;
  endfunction : merge_byte

  // ****************************************************************
  // register read and write
  // ****************************************************************
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == `ADDR_COMPAT_CTRL || a == `ADDR_UNLOCK ||
      a == `ADDR_CHIP_CTRL || a == `ADDR_MODE_CTRL ||
      a == `ADDR_PAGE_CTRL || a == `ADDR_STATUS;
  endfunction : is_mapped

  // a locked control register reads as zero
  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] a,
    input compat_control_pkg::regs_t r,
    input compat_control_pkg::decode_t d
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `ADDR_COMPAT_CTRL: begin
        w = {24'h000000, r.compatibility_control};
        if (!r.unlocked) begin
          w = 32'h0000_0000;
        end
      end
      `ADDR_UNLOCK: begin
        w = {31'h00000000, r.unlocked};
      end
      `ADDR_CHIP_CTRL: begin
        w = {31'h00000000, r.vga_enable};
      end
      `ADDR_MODE_CTRL: begin
        w = {27'h0000000, r.mode_ctrl};
      end
      `ADDR_PAGE_CTRL: begin
        w = {30'h00000000, r.page_ctrl};
      end
      `ADDR_STATUS: begin
        w = {29'h00000000, d.port_3c3_decode, d.host_mem_en,
          d.host_io_en};
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // only byte lane 0 carries data; upper lanes are dropped
  function automatic compat_control_pkg::regs_t write_regs(
    input compat_control_pkg::regs_t r,
    input logic [ADDR_W-1:0] a,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    compat_control_pkg::regs_t n;
    n = r;
    unique case (a)
      `ADDR_COMPAT_CTRL: begin
        n.compatibility_control = merge_byte(
          r.compatibility_control, wd, strb);
      end
      `ADDR_UNLOCK: begin
        if (strb[0]) begin
          // any other value locks the extensions again
          n.unlocked = wd[7:0] == `UNLOCK_KEY;
        end
      end
      `ADDR_CHIP_CTRL: begin
        if (strb[0]) begin
          n.vga_enable = wd[0];
        end
      end
      `ADDR_MODE_CTRL: begin
        if (strb[0]) begin
          n.mode_ctrl = wd[4:0];
        end
      end
      `ADDR_PAGE_CTRL: begin
        if (strb[0]) begin
          n.page_ctrl = wd[1:0];
        end
      end
      default: n = r;
    endcase
    return n;
  endfunction : write_regs

  // ****************************************************************
  // host decode
  // ****************************************************************
  // 3c3 bit 0 only counts while the arm bit is set
  function automatic compat_control_pkg::decode_t host_decode(
    input logic chip_en,
    input logic arm,
    input logic vga_en
  );
    compat_control_pkg::decode_t d;
    d = '0;
    if (chip_en && arm) begin
      d.port_3c3_decode = 1'b1;
      d.host_io_en = vga_en;
      d.host_mem_en = vga_en;
    end else if (chip_en) begin
      // arm clear leaves the ordinary compatible decode
      d.port_3c3_decode = 1'b0;
      d.host_io_en = 1'b1;
      d.host_mem_en = 1'b1;
    end
    return d;
  endfunction : host_decode

  // ****************************************************************
  // crt timing unit address multiplexing
  // ****************************************************************
  function automatic logic [15:0] crt_mux(
    input logic [15:0] cnt,
    input logic [15:0] plain,
    input logic dword,
    input logic ext_en
  );
    logic [15:0] la;
    la = plain;
    if (dword && ext_en) begin
      // top counter bits fold onto the two low linear bits
      la = {cnt[13:0], cnt[15], cnt[14]};
    end
    return la;
  endfunction : crt_mux

  // ****************************************************************
  // display enable skew
  // ****************************************************************
  // widest sum is 3 + 1, so three bits never wrap
  function automatic logic [2:0] skew_sum(
    input logic [1:0] programmed,
    input logic extend
  );
    return {1'b0, programmed} + {2'b00, extend};
  endfunction : skew_sum

  // ****************************************************************
  // text pixel path
  // ****************************************************************
  function automatic logic [7:0] font_merge(
    input logic [7:0] font,
    input logic [7:0] ext_attr,
    input logic ext_en,
    input logic underline
  );
    logic [7:0] px;
    px = font;
    if (ext_en && underline) begin
      // plane 3 byte arrives with the character code
      px = font | ext_attr;
    end
    return px;
  endfunction : font_merge

  logic setup;
  logic access;
  logic unmapped;
  logic ctrl_locked;
  logic [31:0] rd;

  assign setup = psel && !penable;
  assign access = psel && penable && st.apb_state ==
    compat_control_pkg::apb_access;

  always_comb begin
    next_st = st;
    ctrl_locked = !st.regs.unlocked;
    unmapped = !is_mapped(paddr);
    rd = read_word(paddr, st.regs, st.decode);

    // ****************************************************************
    // apb slave: one wait-free access phase
    // ****************************************************************
    next_st.resp.pready = 1'b0;
    next_st.resp.pslverr = 1'b0;
    unique case (st.apb_state)
      compat_control_pkg::apb_idle: begin
        if (setup) begin
          next_st.apb_state = compat_control_pkg::apb_access;
          next_st.resp.pready = 1'b1;
          next_st.resp.pslverr = unmapped ||
            (paddr == `ADDR_COMPAT_CTRL && ctrl_locked);
          next_st.resp.prdata = pwrite ? 32'h0000_0000 : rd;
        end
      end
      compat_control_pkg::apb_access: begin
        next_st.apb_state = compat_control_pkg::apb_idle;
        next_st.resp.prdata = 32'h0000_0000;
      end
      default: next_st.apb_state = compat_control_pkg::apb_idle;
    endcase

    // a refused access never reaches the registers
    if (access && pwrite && !st.resp.pslverr) begin
      next_st.regs = write_regs(st.regs, paddr, pwdata, pstrb);
    end

    // ****************************************************************
    // host decode
    // ****************************************************************
    next_st.decode = host_decode(chip_enable_pin,
      st.regs.compatibility_control[`BIT_IO_DECODE_ARM],
      st.regs.vga_enable);

    // ****************************************************************
    // display path
    // ****************************************************************
    next_st.disp.cpu_linear_addr = remap_cpu(cpu_addr,
      st.regs.compatibility_control, st.regs.mode_ctrl,
      st.regs.page_ctrl);
    next_st.disp.crt_linear_addr = crt_mux(crt_mem_counter, crt_std_addr,
      st.regs.mode_ctrl[`BIT_DWORD],
      st.regs.compatibility_control[`BIT_EXT256_EN]);
    next_st.disp.de_skew = skew_sum(
      st.regs.mode_ctrl[`FLD_SKEW_HI:`FLD_SKEW_LO],
      st.regs.compatibility_control[`BIT_DE_SKEW_EXT]);
    // refresh logic counts its one character after the chosen end
    next_st.disp.refresh_skewed =
      st.regs.compatibility_control[`BIT_REFRESH_SKEW];
    next_st.disp.font_out = font_merge(font_data, plane3_ext_attr,
      st.regs.compatibility_control[`BIT_EXT_ATTR_EN],
      underline_line);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.regs.compatibility_control <= `RST_COMPAT_CTRL;
      st.regs.vga_enable <= `RST_VGA_ENABLE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.resp.prdata;
  assign pready = st.resp.pready;
  assign pslverr = st.resp.pslverr;
  assign host_io_en = st.decode.host_io_en;
  assign host_mem_en = st.decode.host_mem_en;
  assign port_3c3_decode = st.decode.port_3c3_decode;
  assign cpu_linear_addr = st.disp.cpu_linear_addr;
  assign crt_linear_addr = st.disp.crt_linear_addr;
  assign de_skew = st.disp.de_skew;
  assign refresh_skewed = st.disp.refresh_skewed;
  assign font_out = st.disp.font_out;

endmodule : compat_control_addressing

/* File: verilog/compat_control_defines.svh */
// offsets, field positions, reset values and unlock key of the compatibility control block
`ifndef COMPAT_CONTROL_DEFINES_SVH
`define COMPAT_CONTROL_DEFINES_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_COMPAT_CTRL 12'h000
`define ADDR_UNLOCK 12'h004
`define ADDR_CHIP_CTRL 12'h008
`define ADDR_MODE_CTRL 12'h00c
`define ADDR_PAGE_CTRL 12'h010
`define ADDR_STATUS 12'h014

// ****************************************************************
// compatibility control fields
// ****************************************************************
`define BIT_IO_DECODE_ARM 7
`define BIT_DE_SKEW_EXT 6
`define BIT_SEQ_CHAIN4 5
`define BIT_SEQ_CHAIN 4
`define BIT_REFRESH_SKEW 3
`define BIT_EXT256_EN 2
`define BIT_EXT256_MODE 1
`define BIT_EXT_ATTR_EN 0

// ****************************************************************
// mode control fields (copies of memory_mode_reg, graphics_misc_reg,
// hblank_end_reg and underline_location_reg bits)
// ****************************************************************
`define BIT_CHAIN4 0
`define BIT_CHAIN 1
`define BIT_DWORD 2
`define FLD_SKEW_LO 3
`define FLD_SKEW_HI 4

// ****************************************************************
// page control fields
// ****************************************************************
`define BIT_PAGE_SEL 0
`define BIT_EXT_PAGE_SEL 1

// ****************************************************************
// reset and key values
// ****************************************************************
`define RST_COMPAT_CTRL 8'h00
`define RST_VGA_ENABLE 1'b0
`define UNLOCK_KEY 8'hea

`endif

/* File: verilog/compat_control_pkg.sv */
// types shared by the compatibility control block
package compat_control_pkg;

  typedef struct packed {
    logic [7:0] compatibility_control;
    logic unlocked;
    logic vga_enable;
    logic [4:0] mode_ctrl;
    logic [1:0] page_ctrl;
  } regs_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_t;

  typedef struct packed {
    logic host_io_en;
    logic host_mem_en;
    logic port_3c3_decode;
  } decode_t;

  typedef struct packed {
    logic [15:0] cpu_linear_addr;
    logic [15:0] crt_linear_addr;
    logic [2:0] de_skew;
    logic refresh_skewed;
    logic [7:0] font_out;
  } display_t;

  typedef enum logic [1:0] {
    apb_idle = 2'b00,
    apb_access = 2'b01
  } apb_state_t;

  typedef struct packed {
    apb_state_t apb_state;
    regs_t regs;
    apb_resp_t resp;
    decode_t decode;
    display_t disp;
  } state_t;

endpackage : compat_control_pkg

/* File: bench/compat_control_monitor.sv */
// checker on the ports of the compatibility control block
`timescale 1ns/1ps
`include "compat_control_defines.svh"
module compat_control_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_enable_pin,
  input wire logic [7:0] font_data,
  input wire logic underline_line,
  input wire logic [7:0] font_out,
  input wire logic host_io_en,
  input wire logic host_mem_en,
  input wire logic port_3c3_decode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata outside answer");
  property p_chip_off;
    !chip_enable_pin |=> !(host_io_en || host_mem_en || port_3c3_decode);
  endproperty
  a_chip_off: assert property (p_chip_off)
    else $error("decode active while chip disabled");
  property p_pair; host_io_en == host_mem_en; endproperty
  a_pair: assert property (p_pair)
    else $error("io and memory decode disagree");
  property p_font_plain;
    $past(presetn) && !$past(underline_line) |-> font_out == $past(font_data);
  endproperty
  a_font_plain: assert property (p_font_plain)
    else $error("font data altered off the underline line");
  property p_font_or;
    $past(presetn) |-> (font_out & $past(font_data)) == $past(font_data);
  endproperty
  a_font_or: assert property (p_font_or)
    else $error("font data bits lost");
  property p_unlock;
    psel && penable && pready && pwrite && paddr == `ADDR_UNLOCK &&
    pwdata[7:0] == `UNLOCK_KEY ##2 psel && !penable &&
    paddr == `ADDR_COMPAT_CTRL |=> !pslverr;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("control register refused after unlock");
  c_refused: cover property (pslverr);
  c_chip_off: cover property (!chip_enable_pin ##1 chip_enable_pin);
  c_underline: cover property (underline_line ##1 font_out != font_data);
endmodule : compat_control_monitor

/* File: bench/host_cpu_model.sv */
// host cpu model issuing apb transfers
`timescale 1ns/1ps
`include "compat_control_defines.svh"
module host_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
  end
  // ******
  // transfers
  // ******
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines must not look like the last value
    pwdata <= ~d;
  endtask : xfer
  task automatic unlock();
    logic [31:0] r;
    logic e;
    xfer(1'b1, `ADDR_UNLOCK, {24'h0, `UNLOCK_KEY}, r, e);
  endtask : unlock
endmodule : host_cpu_model

/* File: bench/tb_compat_control_addressing.sv */
// testbench for the compatibility control block
`timescale 1ns/1ps
`include "compat_control_defines.svh"
module tb_compat_control_addressing;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic chip_enable_pin, underline_line, refresh_skewed;
  logic host_io_en, host_mem_en, port_3c3_decode;
  logic [16:0] cpu_addr;
  logic [15:0] crt_mem_counter, crt_std_addr, cpu_linear_addr;
  logic [15:0] crt_linear_addr;
  logic [7:0] font_data, plane3_ext_attr, font_out;
  logic [2:0] de_skew, dx;
  logic [28:0] remap [9];
  int fail_count = 0;
  int n_checks = 0;
  compat_control_addressing dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .chip_enable_pin,
    .cpu_addr, .crt_mem_counter, .crt_std_addr, .font_data, .plane3_ext_attr,
    .underline_line, .host_io_en, .host_mem_en, .port_3c3_decode,
    .cpu_linear_addr, .crt_linear_addr, .de_skew, .refresh_skewed, .font_out);
  host_cpu_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ******
  // helpers
  // ******
  task automatic check(input string nm, input logic [31:0] x,
      input logic [31:0] y);
    n_checks++;
    if (y !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, x, y);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a,
      input logic [31:0] x, input logic xe);
    host.xfer(1'b0, a, 32'h0, r, e);
    check(nm, x, r);
    check("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask : settle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
  // ******
  // tests
  // ******
  initial begin
    presetn = 1'b0;
    chip_enable_pin = 1'b1;
    underline_line = 1'b0;
    cpu_addr = 17'h0a5c3;
    crt_mem_counter = 16'h8000;
    crt_std_addr = 16'h1234;
    font_data = 8'h81;
    plane3_ext_attr = 8'h3c;
    remap = '{
      {8'h00, 5'h01, 16'ha5c3},
      {8'h20, 5'h01, 16'he970},
      {8'h20, 5'h00, 16'ha5c3},
      {8'h10, 5'h02, 16'hd2e1},
      {8'h10, 5'h03, 16'ha5c3},
      {8'h04, 5'h01, 16'ha5c1},
      {8'h06, 5'h01, 16'ha5c0},
      {8'h06, 5'h00, 16'ha5c3},
      {8'h02, 5'h01, 16'ha5c3}
    };
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl locked", `ADDR_COMPAT_CTRL, 32'h0, 1'b1);
    wr(`ADDR_COMPAT_CTRL, 8'hff);
    host.unlock();
    rd("ctrl", `ADDR_COMPAT_CTRL, 32'h0, 1'b0);
    rd("unmapped", 12'h018, 32'h0, 1'b1);
    $display("test lock done");
    for (int i = 0; i < 8; i++) begin
      wr(`ADDR_COMPAT_CTRL, {i[2], 7'h0});
      wr(`ADDR_CHIP_CTRL, {7'h0, i[0]});
      @(posedge pclk);
      chip_enable_pin <= i[1];
      settle();
      dx = !i[1] ? 3'b000 : i[2] ? {1'b1, i[0], i[0]} : 3'b011;
      rd("status", `ADDR_STATUS, {29'h0, dx}, 1'b0);
      check("decode", {29'h0, dx}, {29'h0, port_3c3_decode, host_mem_en,
        host_io_en});
    end
    $display("test decode done");
    wr(`ADDR_PAGE_CTRL, 8'h02);
    foreach (remap[k]) begin
      wr(`ADDR_COMPAT_CTRL, remap[k][28:21]);
      wr(`ADDR_MODE_CTRL, {3'h0, remap[k][20:16]});
      settle();
      check("la", {16'h0, remap[k][15:0]}, {16'h0, cpu_linear_addr});
    end
    $display("test remap done");
    wr(`ADDR_MODE_CTRL, 8'h1c);
    wr(`ADDR_COMPAT_CTRL, 8'h4c);
    rd("ctrl rw", `ADDR_COMPAT_CTRL, 32'h4c, 1'b0);
    check("skew", 32'h4, {29'h0, de_skew});
    check("refresh", 32'h1, {31'h0, refresh_skewed});
    check("crt low", 32'h2, {30'h0, crt_linear_addr[1:0]});
    wr(`ADDR_COMPAT_CTRL, 8'h00);
    settle();
    check("skew", 32'h3, {29'h0, de_skew});
    check("refresh", 32'h0, {31'h0, refresh_skewed});
    check("crt", 32'h1234, {16'h0, crt_linear_addr});
    $display("test display done");
    wr(`ADDR_COMPAT_CTRL, 8'h01);
    for (int j = 0; j < 3; j++) begin
      if (j == 2) wr(`ADDR_COMPAT_CTRL, 8'h00);
      @(posedge pclk);
      underline_line <= (j != 1);
      settle();
      check("font", (j == 0) ? 32'hbd : 32'h81, {24'h0, font_out});
    end
    $display("test font done");
    print_verdict();
  end
endmodule : tb_compat_control_addressing
bind compat_control_addressing compat_control_monitor #(.ADDR_W(ADDR_W)) mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .chip_enable_pin, .font_data, .underline_line,
  .font_out, .host_io_en, .host_mem_en, .port_3c3_decode);
